// ### rtl/hbsc_top.sv
// Host port strap capture, address decode, byte steering and wait
`timescale 1ns/1ps
`include "hbsc_consts.svh"
// Operation
// - Sample seven straps when reset rises; derive bus mode and settings.
// - Straps 4,2:0 equal 0100 select split-strobe little-endian bus.
// - Strap 5 high gives active-high wait, low gives active-low.
// - Strap 6 high halves bus clock, low passes it 1:1.
// - Select input low picks registers, high picks 160K buffer.
// - Wait stalls the host until read data valid or write accepted.
// - High byte enable plus address bit 0 steer byte or word.
// - Bus clock enable derives from the input clock pin.
module hbsc_top (
	input  wire logic                      clock,
	input  wire logic                      sys_rst,
	input  wire logic                      reset_n,
	input  wire logic [`HBSC_STRAP_W-1:0]  strap_config_input,
	input  wire logic                      device_select_n,
	input  wire logic                      mem_reg_select,
	input  wire logic [`HBSC_ADDR_W-1:0]   address,
	input  wire logic                      low_write_strobe_n,
	input  wire logic                      high_byte_write_enable_n,
	input  wire logic                      read_strobe_n,
	input  wire logic                      bus_start_n,
	input  wire logic                      read_write_n,
	input  wire logic [`HBSC_DATA_W-1:0]   data_in,
	output logic      [`HBSC_DATA_W-1:0]   data_out,
	output logic                           data_oe,
	output logic                           wait_out,
	output logic                           bus_clock_enable,
	output logic                           mode_valid,
	output logic                           wait_active_high,
	output logic                           clock_div2,
	output logic                           strap_reserved_ok,
	output logic                           core_reg_sel,
	output logic                           core_buf_sel,
	output logic      [`HBSC_ADDR_W-1:0]   core_address,
	output logic                           core_write,
	output logic                           core_read,
	output logic      [1:0]                core_byte_en,
	output logic      [`HBSC_DATA_W-1:0]   core_wdata,
	input  wire logic [`HBSC_DATA_W-1:0]   core_rdata,
	input  wire logic                      core_ready
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int PW = `HBSC_STRAP_W + 6;
	// Reset pin starts low so its first release is one clean rising edge
	wire  [PW-1:0] pins_raw = {strap_config_input, reset_n, device_select_n,
		low_write_strobe_n, read_strobe_n, bus_start_n, read_write_n};
	logic [PW-1:0] pins_s;
	hbsc_sync #(.W(PW)) u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.pin_in  (pins_raw),
		.rst_val ({`HBSC_STRAP_RST, `HBSC_PIN_RST}),
		.pin_out (pins_s)
	);
	wire [`HBSC_STRAP_W-1:0] strap_s = pins_s[PW-1:6];
	wire rstn_s  = pins_s[5];
	wire sel_s   = ~pins_s[4];
	wire wr_s    = ~pins_s[3];
	wire rd_s    = ~pins_s[2];
	wire ctl_high = pins_s[1] & pins_s[0]; // Both must idle high in this bus variant
	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	logic                     rstn_d_r;
	logic [`HBSC_STRAP_W-1:0] strap_r;
	// Filtered pin, so a noisy release captures only once
	wire  rst_rise = rstn_s & ~rstn_d_r;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rstn_d_r <= 1'h0;
			strap_r  <= `HBSC_STRAP_RST;
		end else begin
			rstn_d_r <= rstn_s;
			if (rst_rise) begin
				strap_r <= strap_s;
			end
		end
	end
	// ----------------------------------------
	// Strap decode
	// ----------------------------------------
	wire [3:0] bus_sel = {strap_r[`HBSC_STRAP_BUSHI], strap_r[2:0]};
	assign mode_valid        = (bus_sel == `HBSC_BUSSEL_G2LE);
	assign strap_reserved_ok = strap_r[`HBSC_STRAP_RSVD];
	assign wait_active_high  = strap_r[`HBSC_STRAP_WAITPOL];
	assign clock_div2        = strap_r[`HBSC_STRAP_CLKDIV];
	// ----------------------------------------
	// Bus clock divider
	// ----------------------------------------
	// Enable pulse rather than a derived clock keeps one domain
	logic div_r;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_r <= 1'h0;
		end else begin
			div_r <= ~div_r;
		end
	end
	assign bus_clock_enable = clock_div2 ? div_r : 1'h1;
	// ----------------------------------------
	// Decode and steering
	// ----------------------------------------
	function automatic logic [1:0] hbsc_lanes(input logic hi_n, input logic a0);
		hbsc_lanes = {~hi_n, ~a0 | hi_n};
	endfunction
	// Requests are ignored while the straps name another bus
	wire active = rstn_s & mode_valid & sel_s & ctl_high;
	hbsc_pkg::hbsc_space_type space;
	assign space = !active ? hbsc_pkg::HBSC_SPACE_NONE :
		(mem_reg_select ? hbsc_pkg::HBSC_SPACE_BUF : hbsc_pkg::HBSC_SPACE_REG);
	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	hbsc_pkg::hbsc_state_type state_r;
	hbsc_pkg::hbsc_state_type state_nxt;
	wire req = (space != hbsc_pkg::HBSC_SPACE_NONE) & (wr_s ^ rd_s) & bus_clock_enable;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			hbsc_pkg::HBSC_IDLE: begin
				if (req) begin
					state_nxt = hbsc_pkg::HBSC_STALL;
				end
			end
			hbsc_pkg::HBSC_STALL: begin
				if (core_ready) begin
					state_nxt = hbsc_pkg::HBSC_DONE;
				end
			end
			hbsc_pkg::HBSC_DONE: begin
				if (!sel_s || !(wr_s | rd_s)) begin
					state_nxt = hbsc_pkg::HBSC_IDLE;
				end
			end
			default: state_nxt = hbsc_pkg::HBSC_IDLE;
		endcase
	end
	wire  take = req & (state_r == hbsc_pkg::HBSC_IDLE);
	wire  stalling = (state_r == hbsc_pkg::HBSC_STALL) | take;
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= hbsc_pkg::HBSC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	// Address and data are pins, but stand still while the synced strobe is low
	logic [1:0]               lanes_r;
	logic                     is_wr_r;
	logic                     is_buf_r;
	logic [`HBSC_ADDR_W-1:0]  addr_r;
	logic [`HBSC_DATA_W-1:0]  wdata_r;
	wire  [1:0]               lanes_nxt = hbsc_lanes(high_byte_write_enable_n, address[0]);
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lanes_r  <= 2'h0;
			is_wr_r  <= 1'h0;
			is_buf_r <= 1'h0;
			addr_r   <= 18'h00000;
			wdata_r  <= 16'h0000;
		end else if (take) begin
			lanes_r  <= lanes_nxt;
			is_wr_r  <= wr_s;
			is_buf_r <= (space == hbsc_pkg::HBSC_SPACE_BUF);
			addr_r   <= address;
			wdata_r  <= data_in;
		end
	end
	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [`HBSC_DATA_W-1:0]  rdata_r;
	wire  in_stall = (state_r == hbsc_pkg::HBSC_STALL);
	wire  rd_take  = in_stall & core_ready & ~is_wr_r;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_r <= 16'h0000;
		end else if (rd_take) begin
			rdata_r <= core_rdata;
		end
	end
	// ----------------------------------------
	// Core side outputs
	// ----------------------------------------
	// Buffer block past its end still completes, but selects nothing
	wire  buf_in_range = ({14'h0, addr_r} < `HBSC_BUF_BYTES);
	assign core_reg_sel = in_stall & ~is_buf_r;
	assign core_buf_sel = in_stall & is_buf_r & buf_in_range;
	assign core_write   = in_stall & is_wr_r;
	assign core_read    = in_stall & ~is_wr_r;
	assign core_byte_en = in_stall ? lanes_r : 2'h0;
	assign core_address = addr_r;
	assign core_wdata   = wdata_r;
	// ----------------------------------------
	// Host side outputs
	// ----------------------------------------
	assign data_out     = rdata_r;
	// Drive only while the host still reads, so a released bus is never fought
	assign data_oe      = (state_r == hbsc_pkg::HBSC_DONE) & ~is_wr_r & sel_s & rd_s;
	// Wait asserted at strap polarity only while stalling, else inactive
	assign wait_out = (stalling & sel_s) ? wait_active_high : ~wait_active_high;
endmodule

// ### shared/hbsc_consts.svh
// Constants for the host bus strap configuration block
`ifndef HBSC_CONSTS_SVH
`define HBSC_CONSTS_SVH
`define HBSC_STRAP_W        7
`define HBSC_STRAP_RST      7'h08
`define HBSC_PIN_RST        6'h1F
`define HBSC_BUSSEL_G2LE    4'h4
`define HBSC_STRAP_RSVD     3
`define HBSC_STRAP_WAITPOL  5
`define HBSC_STRAP_CLKDIV   6
`define HBSC_STRAP_BUSHI    4
`define HBSC_ADDR_W         18
`define HBSC_DATA_W         16
`define HBSC_BUF_BYTES      32'h00028000
`define HBSC_SYNC_STAGES    3
`define HBSC_ACCESS_CYCLES  3'h2
`endif

// ### shared/hbsc_pkg.sv
// Types for the host bus strap configuration block
package hbsc_pkg;
	typedef enum logic [1:0] {
		HBSC_SPACE_NONE,
		HBSC_SPACE_REG,
		HBSC_SPACE_BUF
	} hbsc_space_type;
	typedef enum {
		HBSC_IDLE,
		HBSC_STALL,
		HBSC_DONE
	} hbsc_state_type;
endpackage

// ### rtl/hbsc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "hbsc_consts.svh"
module hbsc_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	wire  [W-1:0] agree = ~(s2_r ^ s3_r);
	wire  [W-1:0] out_nxt = (agree & s2_r) | (~agree & out_r);
	always_ff @(posedge clock) begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
		if (sys_rst) begin
			out_r <= rst_val;
		end else begin
			out_r <= out_nxt;
		end
	end
	assign pin_out = out_r;
endmodule

// ### test/hbsc_top_asserts.sv
// Checker for strap capture, clock divide and wait behaviour
`timescale 1ns/1ps
module hbsc_chk (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       reset_n,
	input wire logic       wait_out,
	input wire logic       mode_valid,
	input wire logic       wait_active_high,
	input wire logic       clock_div2,
	input wire logic       bus_clock_enable,
	input wire logic       core_reg_sel,
	input wire logic       core_buf_sel,
	input wire logic       core_read,
	input wire logic       core_write,
	input wire logic       core_ready,
	input wire logic [1:0] core_byte_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic act = core_read | core_write;
	property p_idle; !mode_valid |-> wait_out != wait_active_high; endproperty
	a_idle: assert property (p_idle) else $error("wait active with no valid mode");
	property p_stall; act |-> wait_out == wait_active_high; endproperty
	a_stall: assert property (p_stall) else $error("core access without wait");
	property p_rel; act && core_ready |=> wait_out != wait_active_high; endproperty
	a_rel: assert property (p_rel) else $error("wait held after core ready");
	property p_be; act |-> core_byte_en != 2'h0; endproperty
	a_be: assert property (p_be) else $error("access with no byte lane");
	property p_space; !(core_reg_sel && core_buf_sel); endproperty
	a_space: assert property (p_space) else $error("both spaces selected");
	property p_div1; mode_valid && !clock_div2 |-> bus_clock_enable; endproperty
	a_div1: assert property (p_div1) else $error("bus clock gated at 1:1");
	property p_div2; clock_div2 && $stable(clock_div2) && bus_clock_enable |=> !bus_clock_enable;
	endproperty
	a_div2: assert property (p_div2) else $error("bus clock not halved");
	property p_hold; reset_n [*8] |-> $stable(clock_div2) && $stable(wait_active_high); endproperty
	a_hold: assert property (p_hold) else $error("straps changed after capture");
endmodule
bind hbsc_top hbsc_chk u_chk (
	.clock            (clock),
	.sys_rst          (sys_rst),
	.reset_n          (reset_n),
	.wait_out         (wait_out),
	.mode_valid       (mode_valid),
	.wait_active_high (wait_active_high),
	.clock_div2       (clock_div2),
	.bus_clock_enable (bus_clock_enable),
	.core_reg_sel     (core_reg_sel),
	.core_buf_sel     (core_buf_sel),
	.core_read        (core_read),
	.core_write       (core_write),
	.core_ready       (core_ready),
	.core_byte_en     (core_byte_en)
);

// ### test/hbsc_host_model.sv
// Host processor model for the split-strobe bus port
`timescale 1ns/1ps
module hbsc_host_model (
	input  wire logic        clock,
	input  wire logic        wait_out,
	input  wire logic        host_wait_pol,
	input  wire logic        data_oe,
	input  wire logic [15:0] data_out,
	output logic             device_select_n,
	output logic             mem_reg_select,
	output logic             high_byte_write_enable_n,
	output logic             low_write_strobe_n,
	output logic             read_strobe_n,
	output logic             bus_start_n,
	output logic             read_write_n,
	output logic      [17:0] address,
	output logic      [15:0] data_in
);
	// Window, acknowledge tie and pin routing taken as set up
	initial begin
		{device_select_n, mem_reg_select, high_byte_write_enable_n} = 3'h7;
		{low_write_strobe_n, read_strobe_n, bus_start_n, read_write_n} = 4'hF;
		address = 18'h00000;
		data_in = 16'h0000;
	end
	task automatic access(input logic wr, ms, hb, input logic [17:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok, output logic oe);
		logic seen;
		seen = 1'h0;
		ok = 1'h0;
		@(negedge clock);
		{device_select_n, mem_reg_select, high_byte_write_enable_n} <= {1'h0, ms, hb};
		{address, data_in, low_write_strobe_n, read_strobe_n} <= {a, wd, !wr, wr};
		for (int n = 0; n < 40 && !ok; n++) begin
			@(negedge clock);
			if (wait_out === host_wait_pol) seen = 1'h1;
			else if (seen) ok = 1'h1;
		end
		rd = data_out;
		oe = data_oe;
		// Released lines show the inverse, never a stale copy
		{device_select_n, low_write_strobe_n, read_strobe_n, address, data_in} <= {3'h7, ~a, ~wd};
		repeat (6) @(negedge clock);
	endtask
endmodule

// ### test/tb_hbsc_top.sv
// Testbench for the host port strap capture and decode block
`timescale 1ns/1ps
module tb_hbsc_top;
	logic clock = 1'h0, sys_rst = 1'h1, reset_n = 1'h0, core_ready = 1'h0, host_wait_pol = 1'h0;
	logic device_select_n, mem_reg_select, high_byte_write_enable_n, low_write_strobe_n;
	logic read_strobe_n, bus_start_n, read_write_n, data_oe, wait_out, bus_clock_enable, ok;
	logic mode_valid, wait_active_high, clock_div2, strap_reserved_ok, core_reg_sel;
	logic core_buf_sel, core_write, core_read, s_reg, s_buf, oe;
	logic [6:0]  strap_config_input = 7'h08;
	logic [1:0]  core_byte_en, s_be;
	logic [17:0] address, core_address;
	logic [15:0] data_in, data_out, core_wdata, core_rdata, s_wd, rd;
	int err_count = 0, num_checks = 0;
	hbsc_top dut (
		.clock (clock), .sys_rst (sys_rst), .reset_n (reset_n),
		.strap_config_input (strap_config_input), .device_select_n (device_select_n),
		.mem_reg_select (mem_reg_select), .address (address),
		.low_write_strobe_n (low_write_strobe_n),
		.high_byte_write_enable_n (high_byte_write_enable_n),
		.read_strobe_n (read_strobe_n), .bus_start_n (bus_start_n),
		.read_write_n (read_write_n), .data_in (data_in), .data_out (data_out),
		.data_oe (data_oe), .wait_out (wait_out), .bus_clock_enable (bus_clock_enable),
		.mode_valid (mode_valid), .wait_active_high (wait_active_high),
		.clock_div2 (clock_div2), .strap_reserved_ok (strap_reserved_ok),
		.core_reg_sel (core_reg_sel), .core_buf_sel (core_buf_sel),
		.core_address (core_address), .core_write (core_write), .core_read (core_read),
		.core_byte_en (core_byte_en), .core_wdata (core_wdata), .core_rdata (core_rdata),
		.core_ready (core_ready)
	);
	hbsc_host_model host (
		.clock (clock), .wait_out (wait_out), .host_wait_pol (host_wait_pol),
		.data_oe (data_oe), .data_out (data_out), .device_select_n (device_select_n),
		.mem_reg_select (mem_reg_select),
		.high_byte_write_enable_n (high_byte_write_enable_n),
		.low_write_strobe_n (low_write_strobe_n), .read_strobe_n (read_strobe_n),
		.bus_start_n (bus_start_n), .read_write_n (read_write_n), .address (address),
		.data_in (data_in)
	);
	assign core_rdata = core_address[15:0] ^ 16'h5A5A;
	always #4 clock = ~clock;
	always @(negedge clock) core_ready <= core_read | core_write;
	always @(negedge clock) if (core_read | core_write)
		{s_be, s_reg, s_buf, s_wd} <= {core_byte_en, core_reg_sel, core_buf_sel, core_wdata};
	task chk(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task boot(input logic [6:0] s);
		@(negedge clock);
		{sys_rst, reset_n, strap_config_input} <= {2'h2, s};
		repeat (10) @(negedge clock);
		sys_rst <= 1'h0;
		repeat (5) @(negedge clock);
		reset_n <= 1'h1;
		repeat (12) @(negedge clock);
	endtask
	initial begin
		ok = 1'h1;
		for (int i = 0; i < 4 && ok; i++) begin
			host_wait_pol = i[0];
			boot({i[1], i[0], 5'h0C});
			chk({mode_valid, strap_reserved_ok, wait_out}, {2'h3, !i[0]});
			chk({wait_active_high, clock_div2}, {i[0], i[1]});
			strap_config_input <= 7'h00;
			repeat (10) @(negedge clock);
			chk({wait_active_high, clock_div2, mode_valid}, {i[0], i[1], 1'h1});
			host.access(1'h1, 1'h0, i[0], 18'h00104, 16'hC3A5, rd, ok, oe);
			chk({ok, oe, s_be, s_reg, s_buf, s_wd}, {2'h2, !i[0], 3'h6, 16'hC3A5});
			host.access(1'h0, 1'h1, 1'h0, 18'h27FFF, 16'h0000, rd, ok, oe);
			chk({ok, oe, s_be, s_reg, s_buf, rd}, {2'h3, 2'h2, 2'h1, 16'h25A5});
			$display("test %0d done", i);
		end
		if (ok) begin
			host.access(1'h0, 1'h1, 1'h0, 18'h28000, 16'h0000, rd, ok, oe);
			chk({ok, oe, s_reg, s_buf, rd}, {2'h3, 2'h0, 16'hDA5A});
			$display("test buffer limit done");
		end
		if (ok) begin
			host_wait_pol = 1'h0;
			boot(7'h0D);
			host.access(1'h1, 1'h0, 1'h0, 18'h00104, 16'h1234, rd, ok, oe);
			chk({ok, oe, mode_valid, wait_out}, {3'h0, 1'h1});
			$display("test refused mode done");
		end
		finish_test();
	end
endmodule
